// file: rtl/pfs_status_bytes.v
/*
 Paged, read-only output voltage, output current and temperature status
 bytes of a two-channel buck controller. Assumes the serial bus engine
 hands over page writes and byte-read requests as one-cycle strobes, and
 that fault inputs are synchronous to sys_clk.
*/
// What this block does
// - A read of the voltage status command returns one byte of the selected channel's voltage faults.
// - Voltage faults arrive on two inputs per channel, over-voltage and under-voltage.
// - Page 00h selects channel 1, page 01h channel 2, page 11h channel 1 for reads.
// - Bit 7 of the voltage byte is the over-voltage fault flag, latched from the over-voltage input.
// - Bit 4 of the voltage byte is the under-voltage fault flag, latched from the feedback under-voltage input.
// - A slave channel reads its over- and under-voltage flags as zero.
// - The under-voltage flag follows only the feedback under-voltage input, never over-current.
// - The current byte takes its faults from an over-current fault and a warning input per channel.
// - Bit 7 of the current byte is the over-current fault flag.
// - Bit 5 of the current byte is the over-current warning flag.
// - Bit 7 of the temperature byte is the over-temperature fault flag.
// - Bit 6 of the temperature byte is the over-temperature warning flag.
// - All three bytes reset to zero and undefined bits always read zero.
// - With page 11h a paged read returns the channel 1 contents.
// - Current and temperature flags report per channel whether master or slave.
`include "pfs_map.vh"
`default_nettype none
module pfs_status_bytes
(
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Fault inputs, bit 0 channel 1, bit 1 channel 2
   input wire [1:0] overvoltage_fault_in,
   input wire [1:0] feedback_undervoltage_in,
   input wire [1:0] overcurrent_fault_in,
   input wire [1:0] overcurrent_warning_in,
   input wire [1:0] overtemp_fault_in,
   input wire [1:0] overtemp_warning_in,
   input wire [1:0] channel_is_slave,
   // Per-channel flag clear, one-cycle pulse
   input wire [1:0] flags_clear,
   // Page command write
   input wire page_write,
   input wire [7:0] page_wdata,
   // Byte read and write requests from the serial engine
   input wire cmd_read,
   input wire cmd_write,
   input wire [7:0] cmd_code,
   // Read answer
   output reg [7:0] rdata_reg,
   output reg rvalid_reg,
   output reg unsupported_reg,
   output reg [7:0] page_reg
);
   wire [5:0] flags_ch1;
   wire [5:0] flags_ch2;
   wire [5:0] sel_flags;
   wire sel_slave;
   reg [7:0] byte_next;
   reg hit_next;
   reg [7:0] page_next;

   // Event vector: {otw, otf, ocw, ocf, uvf, ovf}
   pfs_flag_latch u_ch1
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .set_in({overtemp_warning_in[0], overtemp_fault_in[0], overcurrent_warning_in[0],
         overcurrent_fault_in[0], feedback_undervoltage_in[0],
         overvoltage_fault_in[0]}),
      .clear(flags_clear[0]),
      .flags_reg(flags_ch1)
   );
   pfs_flag_latch u_ch2
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .set_in({overtemp_warning_in[1], overtemp_fault_in[1], overcurrent_warning_in[1],
         overcurrent_fault_in[1], feedback_undervoltage_in[1],
         overvoltage_fault_in[1]}),
      .clear(flags_clear[1]),
      .flags_reg(flags_ch2)
   );

   // Page 01h picks channel 2; 00h and 11h read channel 1
   assign sel_flags = (page_reg == `PFS_PAGE_CH2) ? flags_ch2 : flags_ch1;
   assign sel_slave = (page_reg == `PFS_PAGE_CH2) ? channel_is_slave[1] : channel_is_slave[0];

   always @*
   begin
      byte_next = `PFS_STATUS_RESET;
      hit_next = 1'b1;
      case (cmd_code)
         `PFS_CMD_VOUT_STATUS:
         begin
            byte_next[`PFS_BIT_OVF] = sel_flags[0] & ~sel_slave;
            byte_next[`PFS_BIT_UVF] = sel_flags[1] & ~sel_slave;
         end
         `PFS_CMD_IOUT_STATUS:
         begin
            byte_next[`PFS_BIT_OCF] = sel_flags[2];
            byte_next[`PFS_BIT_OCW] = sel_flags[3];
         end
         `PFS_CMD_TEMP_STATUS:
         begin
            byte_next[`PFS_BIT_OTF] = sel_flags[4];
            byte_next[`PFS_BIT_OTW] = sel_flags[5];
         end
         default:
            hit_next = 1'b0;
      endcase
   end

   // Only the three documented page values are accepted
   always @*
   begin
      page_next = page_reg;
      if (page_write && (page_wdata == `PFS_PAGE_CH1 || page_wdata == `PFS_PAGE_CH2 ||
         page_wdata == `PFS_PAGE_BOTH))
         page_next = page_wdata;
   end

   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         rdata_reg <= `PFS_STATUS_RESET;
         rvalid_reg <= 1'b0;
         unsupported_reg <= 1'b0;
         page_reg <= `PFS_PAGE_CH1;
      end
      else
      begin
         page_reg <= page_next;
         rvalid_reg <= cmd_read;
         // Writes to status codes are refused and touch no flag
         unsupported_reg <= (cmd_read & ~hit_next) | (cmd_write & hit_next);
         if (cmd_read)
            rdata_reg <= hit_next ? byte_next : `PFS_STATUS_RESET;
      end
   end
endmodule // pfs_status_bytes
`default_nettype wire

// file: rtl/pfs_map.vh
/*
 Command codes, bit positions, page codes and reset values of the paged
 fault status bytes. Assumes it is included by bare name from rtl files.
*/
`ifndef PFS_MAP_VH
`define PFS_MAP_VH
`define PFS_CMD_VOUT_STATUS 8'h7a
`define PFS_CMD_IOUT_STATUS 8'h7b
`define PFS_CMD_TEMP_STATUS 8'h7d
`define PFS_PAGE_CH1 8'h00
`define PFS_PAGE_CH2 8'h01
`define PFS_PAGE_BOTH 8'h11
`define PFS_BIT_OVF 7
`define PFS_BIT_UVF 4
`define PFS_BIT_OCF 7
`define PFS_BIT_OCW 5
`define PFS_BIT_OTF 7
`define PFS_BIT_OTW 6
`define PFS_STATUS_RESET 8'h00
`define PFS_NCH 2
`endif

// file: rtl/pfs_flag_latch.v
/*
 One channel's sticky fault flags: six latches set by fault inputs.
 Assumes fault inputs synchronous to sys_clk; clear is a one-cycle pulse.
*/
`default_nettype none
module pfs_flag_latch
(
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Fault events and clear
   input wire [5:0] set_in,
   input wire clear,
   // Latched flags
   output reg [5:0] flags_reg
);
   wire [5:0] flags_next;
   // Set wins over a clear in the same cycle
   assign flags_next = clear ? set_in : (flags_reg | set_in);
   always @(posedge sys_clk)
   begin
      if (reset)
         flags_reg <= 6'h00;
      else
         flags_reg <= flags_next;
   end
endmodule // pfs_flag_latch
`default_nettype wire

// file: sim/pfs_status_bytes_asserts.sv
/* Port checks of the status bytes. Bound into pfs_status_bytes. */
`default_nettype none
module pfs_status_bytes_asserts (
   input wire logic sys_clk, reset, page_write, cmd_read, cmd_write, rvalid_reg, unsupported_reg,
   input wire logic [1:0] overcurrent_fault_in, channel_is_slave, flags_clear,
   input wire logic [7:0] page_wdata, cmd_code, rdata_reg, page_reg
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_oc_read;
      overcurrent_fault_in[0] ##1
         cmd_read && cmd_code == 8'h7b && page_reg == 8'h00 && !flags_clear[0];
   endsequence
   a_read_answer: assert property (cmd_read |=> rvalid_reg)
      else $error("no answer");
   a_vout_spare: assert property (rvalid_reg && $past(cmd_code) == 8'h7a |-> !(rdata_reg & 8'h6f))
      else $error("vout spare");
   a_iout_spare: assert property (rvalid_reg && $past(cmd_code) == 8'h7b |-> !(rdata_reg & 8'h5f))
      else $error("iout spare");
   a_temp_spare: assert property (rvalid_reg && $past(cmd_code) == 8'h7d |-> !(rdata_reg & 8'h3f))
      else $error("temp spare");
   a_slave_masked: assert property (cmd_read && cmd_code == 8'h7a && channel_is_slave[0]
      && page_reg != 8'h01 |=> rdata_reg[7:4] == 4'h0) else $error("slave vout");
   a_oc_flag: assert property (s_oc_read |=> rdata_reg[7])
      else $error("oc flag");
   a_write_refused: assert property (cmd_write && cmd_code == 8'h7b |=> unsupported_reg)
      else $error("write taken");
   a_page_taken: assert property (page_write && page_wdata inside {8'h00, 8'h01, 8'h11}
      |=> page_reg == $past(page_wdata)) else $error("page");
endmodule // pfs_status_bytes_asserts
bind pfs_status_bytes pfs_status_bytes_asserts chk (.*);
`default_nettype wire

// file: sim/pfs_host_model.sv
/* Host model issuing page writes and byte requests; tasks entered after a falling edge. */
`default_nettype none
module pfs_host_model (
   input wire logic sys_clk,
   output logic page_write, cmd_read, cmd_write,
   output logic [7:0] page_wdata, cmd_code
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {page_write, cmd_read, cmd_write, page_wdata, cmd_code} = '0;
   // Kind 0 page write, 1 read, 2 write; held one clock
   task automatic req(input int k, input logic [7:0] v);
      {page_write, cmd_read, cmd_write} = 3'b100 >> k;
      {page_wdata, cmd_code} = {v, v};
      @(negedge sys_clk);
   endtask
   // Released data lines flip so stale values never look valid
   task automatic idle();
      {page_write, cmd_read, cmd_write, page_wdata, cmd_code} = {3'b0, ~page_wdata, ~cmd_code};
   endtask
endmodule // pfs_host_model
`default_nettype wire

// file: sim/pfs_status_bytes_tb_top.sv
/* Bench of the status bytes. Assumes the host model and the bound checker. */
`default_nettype none
module pfs_status_bytes_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, reset = 1, page_write, cmd_read, cmd_write, rvalid_reg, unsupported_reg;
   logic [7:0] page_wdata, cmd_code, rdata_reg, page_reg, p;
   logic [1:0] ov = 0, uv = 0, oc = 0, ow = 0, tf = 0, tw = 0, sl = 0, fc = 0;
   logic [8:0] exp_q[$];
   int fail_count = 0, tests_run = 0, cyc = 0, c;
   pfs_host_model host (.sys_clk, .page_write, .cmd_read, .cmd_write, .page_wdata, .cmd_code);
   pfs_status_bytes uut (.sys_clk, .reset, .overvoltage_fault_in(ov), .feedback_undervoltage_in(uv),
      .overcurrent_fault_in(oc), .overcurrent_warning_in(ow), .overtemp_fault_in(tf),
      .overtemp_warning_in(tw), .channel_is_slave(sl), .flags_clear(fc), .page_write, .page_wdata,
      .cmd_read, .cmd_write, .cmd_code, .rdata_reg, .rvalid_reg, .unsupported_reg, .page_reg);
   initial forever #5 sys_clk = ~sys_clk;
   task automatic check(input logic [8:0] got, input logic [8:0] want);
      tests_run++;
      if (got !== want)
      begin
         fail_count++;
         $display("Error t=%0t got %h exp %h", $time, got, want);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [7:0] code, input logic [8:0] e);
      exp_q.push_back(e);
      host.req(1, code);
   endtask
   always @(negedge sys_clk)
   begin
      cyc++;
      if (rvalid_reg === 1'b1)
         check({unsupported_reg, rdata_reg}, exp_q.pop_front());
      if (cyc == 3000)
      begin
         fail_count++;
         finish_test();
      end
   end
   initial
   begin
      void'($urandom(32'he26a5041));
      repeat (20) @(negedge sys_clk);
      reset = 0;
      rd(8'h7a, 9'h0);
      rd(8'h7d, 9'h0);
      repeat (40)
      begin
         p = ($urandom % 3 == 2) ? 8'h11 : 8'($urandom % 2);
         {ov, uv, oc, ow, tf, tw, sl} = 14'($urandom);
         host.req(0, p);
         host.req(0, 8'h02);
         c = p == 8'h01;
         rd(8'h7a, {1'b0, ov[c] & ~sl[c], 2'b0, uv[c] & ~sl[c], 4'h0});
         rd(8'h7b, {1'b0, oc[c], 1'b0, ow[c], 5'h0});
         host.req(2, 8'h7b);
         rd(8'h7c, 9'h100);
         rd(8'h7b, {1'b0, oc[c], 1'b0, ow[c], 5'h0});
         rd(8'h7d, {1'b0, tf[c], tw[c], 6'h0});
         host.idle();
         check({1'b0, page_reg}, {1'b0, p});
         {ov, uv, oc, ow, tf, tw, fc} = 14'h0003;
         @(negedge sys_clk);
         fc = 0;
      end
      finish_test();
   end
endmodule // pfs_status_bytes_tb_top
`default_nettype wire
